// ---- src/mdt_timer.sv ----
// Multimode 16-bit down-counter timer with Avalon-MM register slave
// What this block does
// - Stopped: counter write loads reload and counter
// - Running: write reaches reload, then counter, next ticks
// - Timer mode decrements; tick at zero underflows, interrupts
// - Pulse mode toggles both pins per underflow
// - Output pin enable bit turns on the output pin driver
// - Polarity bit sets starting pulse level
// - Port buffer off makes inout pin undriven
// - Event mode counts pin events, gated, filtered
// - Event mode still toggles output pin
// - Gate changes act after two pin events
// - Forced stop clears gating history, avoiding stale counts
// - Width mode counts level, flags its end
// - Width mode underflow sets flag, interrupts
// - Period edge captures count on next tick
// - Following tick reloads, sets edge flag, interrupts
// - Capture held until read; unread keeps old
// - Period mode counter reads return captured value
// - Period mode underflow sets flag, interrupts
// - Link source counts link rising edges
// - Filter samples at clock, /8, /32; three matches
// - Gate polarity picks low or high window
// - Status follows run request after three ticks, or two clocks when linked or in event mode
// - Forced stop halts, clears run, resets output
`timescale 1ns/1ps
`include "mdt_consts.svh"
module mdt_timer #(
  parameter int CNT_W = 16
) (
  input  wire logic              i_mclk,
  input  wire logic              i_reset,
  input  wire logic [4:0]        i_address,
  input  wire logic              i_read,
  input  wire logic              i_write,
  input  wire logic [31:0]       i_writedata,
  input  wire logic [3:0]        i_byteenable,
  output logic [31:0]            o_readdata,
  output logic                   o_waitrequest,
  input  wire logic              i_timer_inout_pin,
  input  wire logic              i_port_direction_bit,
  input  wire logic              i_external_interrupt_gate_source,
  input  wire logic [3:0]        i_gate_timer_outputs,
  input  wire logic              i_low_speed_clock,
  input  wire logic              i_event_link_input,
  output logic                   o_timer_inout_pin,
  output logic                   o_timer_inout_pin_oe,
  output logic                   o_timer_output_pin,
  output logic                   o_timer_output_pin_oe,
  output logic                   o_timer_interrupt_request
);
  // Registers
  logic             run_q, stat_q, edge_q, undf_q;
  logic [7:0]       ioc_q, mode_q, gsel_q;
  logic [CNT_W-1:0] cnt_q, reload_q, wval_q, buf_q;
  logic             buf_full_q, pend1_q, pend2_q, tog_q, ack_q, irq_q;
  logic [1:0]       sync_cnt_q, gate_pipe_q;
  logic [4:0]       pre_q;
  logic             filt_prev_q, link_prev_q, low_prev_q;
  logic [1:0]       pin_s_q, ext_s_q, low_s_q;
  logic [7:0]       tmr_s_q;
  logic [31:0]      rdata_q;
  mdt_pkg::mdt_pp_state_t pp_q;
  logic             filt_pin;

  // Bus decode: waitrequest for one cycle, then the access completes
  wire        req      = i_read | i_write;
  wire        wr_en    = i_write & ack_q;
  wire        rd_en    = i_read & ack_q;
  wire        be0      = i_byteenable[0];
  wire        wr_ctrl  = wr_en & be0 & (i_address == `MDT_OFF_CTRL);
  wire        wr_ioc   = wr_en & be0 & (i_address == `MDT_OFF_IOC);
  wire        wr_mode  = wr_en & be0 & (i_address == `MDT_OFF_MODE);
  wire        wr_gsel  = wr_en & be0 & (i_address == `MDT_OFF_GSEL);
  wire        wr_cnt   = wr_en & (i_address == `MDT_OFF_CNT) & (&i_byteenable[1:0]);
  wire        rd_cnt   = rd_en & (i_address == `MDT_OFF_CNT);
  wire        stop_req = wr_ctrl & i_writedata[`MDT_CTRL_STOP];
  // Any control byte write with a flag bit at zero clears that flag, so run writes clear flags too
  wire        clr_edge = wr_ctrl & ~i_writedata[`MDT_CTRL_EDGE];
  wire        clr_undf = wr_ctrl & ~i_writedata[`MDT_CTRL_UNDF];

  // Field views
  wire [2:0]  md       = mode_q[`MDT_MODE_MOD];
  wire [2:0]  cs       = mode_q[`MDT_MODE_CS];
  wire        pol      = ioc_q[`MDT_IOC_POL];
  wire [1:0]  flt      = ioc_q[`MDT_IOC_FLT];
  wire [1:0]  gate_cd  = ioc_q[`MDT_IOC_GATE];
  wire        is_event = (md == `MDT_MD_EVENT);
  wire        is_width = (md == `MDT_MD_WIDTH);
  wire        is_per   = (md == `MDT_MD_PERIOD);
  wire        is_tog   = (md == `MDT_MD_PULSE) | is_event;
  wire        linked   = (cs == `MDT_CS_LINK) & ~is_event;

  // Internal count sources
  wire tk_div2  = (pre_q & `MDT_DIV2_MASK) == `MDT_DIV2_MASK;
  wire tk_div8  = (pre_q & `MDT_DIV8_MASK) == `MDT_DIV8_MASK;
  wire tk_div32 = (pre_q & `MDT_DIV32_MASK) == `MDT_DIV32_MASK;
  wire tk_low   = low_s_q[1] & ~low_prev_q;
  wire tk_link  = i_event_link_input & ~link_prev_q;
  wire cs_tick  = (cs == `MDT_CS_CLK)  ? 1'b1 :
                  (cs == `MDT_CS_DIV8) ? tk_div8 :
                  (cs == `MDT_CS_DIV2) ? tk_div2 :
                  (cs == `MDT_CS_LOW)  ? tk_low :
                  (cs == `MDT_CS_LINK) ? tk_link : 1'b0;

  // Filter sampling rate
  wire flt_en = (flt == `MDT_FLT_CLK)  ? 1'b1 :
                (flt == `MDT_FLT_DIV8) ? tk_div8 : tk_div32;

  mdt_filter u_filter (
    .i_mclk      (i_mclk),
    .i_reset     (i_reset),
    .i_bypass    (flt == `MDT_FLT_OFF),
    .i_sample_en (flt_en),
    .i_din       (pin_s_q[1]),
    .o_dout      (filt_pin)
  );

  // Pin edges and gating
  wire pin_rise = filt_pin & ~filt_prev_q;
  wire pin_fall = ~filt_pin & filt_prev_q;
  wire pin_edge = mode_q[`MDT_MODE_BOTH] ? (pin_rise | pin_fall) : (pol ? pin_fall : pin_rise);
  wire act_edge = pol ? pin_fall : pin_rise;
  wire tmr_gate = tmr_s_q[{gsel_q[`MDT_GSEL_TMR], 1'b1}];
  wire gate_raw = (gate_cd == `MDT_GATE_EXT) ? ext_s_q[1] : tmr_gate;
  wire gate_lvl = gsel_q[`MDT_GSEL_POL] ? gate_raw : ~gate_raw;
  wire gate_ok  = (gate_cd == `MDT_GATE_NONE) | gate_pipe_q[1];
  wire evt_tick = pin_edge & gate_ok;

  // Count tick for the selected mode; link events are ignored in event mode
  wire tick      = is_event ? evt_tick : cs_tick;
  wire width_act = (filt_pin == pol);
  wire width_end = (filt_prev_q == pol) & ~width_act;
  wire counting  = stat_q & tick & ~pend2_q & (~is_width | width_act);
  wire at_zero   = (cnt_q == CNT_W'(`MDT_CNT_ZERO));
  wire undf_evt  = counting & at_zero;
  wire pp_load   = stat_q & cs_tick & (pp_q == mdt_pkg::MDT_PP_LOAD);
  wire edge_evt  = (stat_q & is_width & width_end) | (is_per & pp_load);
  wire undf_flag = undf_evt & (is_width | is_per);

  // Status synchroniser step: count-source ticks, or CPU clocks when linked or in event mode
  wire sync_step = (linked | is_event) ? 1'b1 : cs_tick;
  wire [1:0] sync_lim = (linked | is_event) ? `MDT_SYNC_CLKS : `MDT_SYNC_TICKS;

  // Readback
  wire [7:0] ctrl_rd = {2'h0, undf_q, edge_q, 2'h0, stat_q, run_q};
  wire [CNT_W-1:0] cnt_rd = is_per ? buf_q : cnt_q;
  wire [31:0] rd_mux =
    (i_address == `MDT_OFF_CTRL) ? {24'h0, ctrl_rd} :
    (i_address == `MDT_OFF_IOC)  ? {24'h0, ioc_q} :
    (i_address == `MDT_OFF_MODE) ? {24'h0, mode_q} :
    (i_address == `MDT_OFF_GSEL) ? {24'h0, gsel_q} :
    (i_address == `MDT_OFF_CNT)  ? {{(32-CNT_W){1'b0}}, cnt_rd} : 32'h0;

  assign o_waitrequest = req & ~ack_q;
  assign o_readdata    = rdata_q;

  // Bus handshake and input synchronisers
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      ack_q       <= 1'b0;
      rdata_q     <= 32'h0;
      pin_s_q     <= 2'h0;
      ext_s_q     <= 2'h0;
      low_s_q     <= 2'h0;
      tmr_s_q     <= 8'h0;
      low_prev_q  <= 1'b0;
      link_prev_q <= 1'b0;
      filt_prev_q <= 1'b0;
      pre_q       <= 5'h0;
    end else begin
      ack_q       <= req & ~ack_q;
      rdata_q     <= (i_read & ~ack_q) ? rd_mux : rdata_q;
      pin_s_q     <= {pin_s_q[0], i_timer_inout_pin};
      ext_s_q     <= {ext_s_q[0], i_external_interrupt_gate_source};
      low_s_q     <= {low_s_q[0], i_low_speed_clock};
      tmr_s_q     <= {tmr_s_q[6], i_gate_timer_outputs[3], tmr_s_q[4], i_gate_timer_outputs[2],
                      tmr_s_q[2], i_gate_timer_outputs[1], tmr_s_q[0], i_gate_timer_outputs[0]};
      low_prev_q  <= low_s_q[1];
      link_prev_q <= i_event_link_input;
      filt_prev_q <= filt_pin;
      pre_q       <= pre_q + 5'h1;
    end
  end

  // Configuration registers
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      ioc_q  <= `MDT_REG_RST;
      mode_q <= `MDT_REG_RST;
      gsel_q <= `MDT_REG_RST;
    end else begin
      if (wr_ioc) begin
        ioc_q <= i_writedata[7:0] & 8'hf5;
      end
      if (wr_mode) begin
        mode_q <= i_writedata[7:0] & 8'h7f;
      end
      if (wr_gsel) begin
        gsel_q <= i_writedata[7:0] & 8'h07;
      end
    end
  end

  // Run control and status synchronisation
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      run_q      <= 1'b0;
      stat_q     <= 1'b0;
      sync_cnt_q <= 2'h0;
    end else if (stop_req) begin
      run_q      <= 1'b0;
      stat_q     <= 1'b0;
      sync_cnt_q <= 2'h0;
    end else begin
      if (wr_ctrl) begin
        run_q <= i_writedata[`MDT_CTRL_RUN];
      end
      if (run_q == stat_q) begin
        sync_cnt_q <= 2'h0;
      end else if (sync_step) begin
        if (sync_cnt_q == sync_lim - 2'h1) begin
          stat_q     <= run_q;
          sync_cnt_q <= 2'h0;
        end else begin
          sync_cnt_q <= sync_cnt_q + 2'h1;
        end
      end
    end
  end

  // Gate window pipeline, stepped by raw events
  always_ff @(posedge i_mclk) begin
    if (i_reset || stop_req) begin
      gate_pipe_q <= 2'h0;
    end else if (pin_edge) begin
      gate_pipe_q <= {gate_pipe_q[0], gate_lvl};
    end
  end

  // Counter, reload and pending write stages
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      cnt_q    <= CNT_W'(`MDT_CNT_RST);
      reload_q <= CNT_W'(`MDT_CNT_RST);
      wval_q   <= CNT_W'(`MDT_CNT_RST);
      pend1_q  <= 1'b0;
      pend2_q  <= 1'b0;
    end else if (wr_cnt && !run_q) begin
      cnt_q    <= i_writedata[CNT_W-1:0];
      reload_q <= i_writedata[CNT_W-1:0];
      pend1_q  <= 1'b0;
      pend2_q  <= 1'b0;
    end else if (stop_req) begin
      pend1_q <= 1'b0;
      pend2_q <= 1'b0;
    end else begin
      if (wr_cnt) begin
        wval_q  <= i_writedata[CNT_W-1:0];
        pend1_q <= 1'b1;
      end else if (pend1_q && tick) begin
        reload_q <= wval_q;
        pend1_q  <= 1'b0;
      end
      if (pend2_q && tick) begin
        cnt_q   <= reload_q;
        pend2_q <= 1'b0;
      end else if (pp_load) begin
        cnt_q <= reload_q;
      end else if (undf_evt) begin
        cnt_q <= reload_q;
      end else if (counting) begin
        cnt_q <= cnt_q - CNT_W'(1);
      end
      if (!wr_cnt && pend1_q && tick) begin
        pend2_q <= 1'b1;
      end
    end
  end

  // Period capture sequence
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      pp_q       <= mdt_pkg::MDT_PP_IDLE;
      buf_q      <= CNT_W'(`MDT_CNT_RST);
      buf_full_q <= 1'b0;
    end else begin
      if (rd_cnt && is_per) begin
        buf_full_q <= 1'b0;
      end
      if (stop_req || !is_per || !stat_q) begin
        pp_q <= mdt_pkg::MDT_PP_IDLE;
      end else begin
        case (pp_q)
          mdt_pkg::MDT_PP_IDLE: begin
            if (act_edge) begin
              pp_q <= mdt_pkg::MDT_PP_CAPT;
            end
          end
          mdt_pkg::MDT_PP_CAPT: begin
            if (cs_tick) begin
              if (!buf_full_q) begin
                buf_q      <= cnt_q;
                buf_full_q <= 1'b1;
              end
              pp_q <= mdt_pkg::MDT_PP_LOAD;
            end
          end
          mdt_pkg::MDT_PP_LOAD: begin
            if (cs_tick) begin
              pp_q <= mdt_pkg::MDT_PP_IDLE;
            end
          end
          default: begin
            pp_q <= mdt_pkg::MDT_PP_IDLE;
          end
        endcase
      end
    end
  end

  // Flags, interrupt and pulse level; a set in the clearing cycle wins
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      edge_q <= 1'b0;
      undf_q <= 1'b0;
      irq_q  <= 1'b0;
      tog_q  <= 1'b0;
    end else begin
      edge_q <= (edge_q & ~clr_edge) | edge_evt;
      undf_q <= (undf_q & ~clr_undf) | undf_flag;
      irq_q  <= undf_evt | edge_evt;
      if (stop_req || wr_mode) begin
        tog_q <= 1'b0;
      end else if (undf_evt && is_tog) begin
        tog_q <= ~tog_q;
      end
    end
  end

  // Output pins: output pin starts at polarity, inout pin at its inverse
  assign o_timer_output_pin        = pol ^ tog_q;
  assign o_timer_output_pin_oe     = ioc_q[`MDT_IOC_OEN];
  assign o_timer_inout_pin         = ~pol ^ tog_q;
  assign o_timer_inout_pin_oe      = (md == `MDT_MD_PULSE) & ~i_port_direction_bit;
  assign o_timer_interrupt_request = irq_q;
endmodule

// ---- common/mdt_consts.svh ----
// Register offsets, field positions, codes and timing counts of the down-counter timer
`ifndef MDT_CONSTS_SVH
`define MDT_CONSTS_SVH
`define MDT_OFF_CTRL   5'h00
`define MDT_OFF_IOC    5'h04
`define MDT_OFF_MODE   5'h08
`define MDT_OFF_GSEL   5'h0c
`define MDT_OFF_CNT    5'h10
`define MDT_CTRL_RUN   0
`define MDT_CTRL_STAT  1
`define MDT_CTRL_STOP  2
`define MDT_CTRL_EDGE  4
`define MDT_CTRL_UNDF  5
`define MDT_IOC_POL    0
`define MDT_IOC_OEN    2
`define MDT_IOC_FLT    5:4
`define MDT_IOC_GATE   7:6
`define MDT_MODE_MOD   2:0
`define MDT_MODE_BOTH  3
`define MDT_MODE_CS    6:4
`define MDT_GSEL_TMR   1:0
`define MDT_GSEL_POL   2
`define MDT_MD_TIMER   3'h0
`define MDT_MD_PULSE   3'h1
`define MDT_MD_EVENT   3'h2
`define MDT_MD_WIDTH   3'h3
`define MDT_MD_PERIOD  3'h4
`define MDT_CS_CLK     3'h0
`define MDT_CS_DIV8    3'h1
`define MDT_CS_DIV2    3'h3
`define MDT_CS_LOW     3'h4
`define MDT_CS_LINK    3'h5
`define MDT_FLT_OFF    2'h0
`define MDT_FLT_CLK    2'h1
`define MDT_FLT_DIV8   2'h2
`define MDT_GATE_EXT   2'h1
`define MDT_GATE_TMR   2'h2
`define MDT_GATE_NONE  2'h0
`define MDT_DIV2_MASK  5'h01
`define MDT_DIV8_MASK  5'h07
`define MDT_DIV32_MASK 5'h1f
`define MDT_SYNC_TICKS 2'h3
`define MDT_SYNC_CLKS  2'h2
`define MDT_CNT_RST    16'hffff
`define MDT_CNT_ZERO   16'h0000
`define MDT_REG_RST    8'h00
`endif

// ---- common/mdt_pkg.sv ----
// Types shared by the down-counter timer modules
package mdt_pkg;
  typedef enum logic [2:0] {
    MDT_PP_IDLE = 3'h1,
    MDT_PP_CAPT = 3'h2,
    MDT_PP_LOAD = 3'h4
  } mdt_pp_state_t;
endpackage

// ---- src/mdt_filter.sv ----
// Three-sample majority-free input filter for the timer pin
`timescale 1ns/1ps
module mdt_filter (
  input  wire logic i_mclk,
  input  wire logic i_reset,
  input  wire logic i_bypass,
  input  wire logic i_sample_en,
  input  wire logic i_din,
  output logic      o_dout
);
  logic [2:0] samp_q;
  wire        agree = (samp_q == 3'h7) || (samp_q == 3'h0);

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      samp_q <= 3'h0;
      o_dout <= 1'b0;
    end else begin
      if (i_sample_en) begin
        samp_q <= {samp_q[1:0], i_din};
      end
      if (i_bypass) begin
        o_dout <= i_din;
      end else if (agree) begin
        o_dout <= samp_q[0];
      end
    end
  end
endmodule

// ---- verif/mdt_partner.sv ----
// Far-side stimulus: measured pulse train and slow count clock
`timescale 1ns/1ps
module mdt_partner (
  input  wire logic       i_mclk,
  input  wire logic       i_reset,
  input  wire logic [7:0] i_half,
  output logic            o_pulse,
  output logic            o_slow_clk
);
  logic [7:0] cnt_q;
  logic [3:0] slow_q;
  // Zero half period parks the line low between measurements
  always_ff @(posedge i_mclk) begin
    slow_q <= i_reset ? 4'h0 : slow_q + 4'h1;
    if (i_reset || i_half == 8'h00) begin
      cnt_q   <= 8'h00;
      o_pulse <= 1'b0;
    end else if (cnt_q == i_half - 8'h01) begin
      cnt_q   <= 8'h00;
      o_pulse <= ~o_pulse;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  assign o_slow_clk = slow_q[3];
endmodule

// ---- verif/mdt_timer_asserts.sv ----
// Port-level checks of the down-counter timer
`timescale 1ns/1ps
module mdt_timer_asserts (
  input wire logic        i_mclk,
  input wire logic        i_reset,
  input wire logic [4:0]  i_address,
  input wire logic        i_read,
  input wire logic        i_write,
  input wire logic [31:0] o_readdata,
  input wire logic        o_waitrequest,
  input wire logic        i_port_direction_bit,
  input wire logic        o_timer_inout_pin_oe,
  input wire logic        o_timer_output_pin,
  input wire logic        o_timer_output_pin_oe,
  input wire logic        o_timer_interrupt_request
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  wire logic req;
  wire logic acc;
  wire logic irq;
  assign req = i_read | i_write;
  assign acc = i_read & ~o_waitrequest;
  assign irq = o_timer_interrupt_request;
  sequence s_start;
    req && !$past(req);
  endsequence
  sequence s_answer;
    ##1 !o_waitrequest;
  endsequence
  wait_first_a: assert property (s_start |-> o_waitrequest) else $error("no wait cycle");
  wait_one_a: assert property (req && o_waitrequest |-> s_answer) else $error("answer late");
  wait_idle_a: assert property (!req |-> !o_waitrequest) else $error("wait while idle");
  rd_unmap_a: assert property (acc && !(i_address inside {5'h00, 5'h04, 5'h08, 5'h0c, 5'h10})
    |-> o_readdata == 32'h0) else $error("unmapped read not zero");
  stop_reads0_a: assert property (acc && i_address == 5'h00 |-> !o_readdata[2])
    else $error("forced stop reads one");
  rd_hold_a: assert property (!acc |-> $stable(o_readdata)) else $error("read data moved");
  pin_buffer_a: assert property (o_timer_inout_pin_oe |-> !i_port_direction_bit)
    else $error("inout driven with buffer off");
  // Writes may legally re-initialise the level, so only quiet periods count
  pulse_irq_a: assert property ($changed(o_timer_output_pin) && o_timer_output_pin_oe
    && $past(o_timer_output_pin_oe) && !$past(i_write) && !$past(i_write, 2)
    |-> ($past(irq) || $past(irq, 2)) or (##[0:2] irq)) else $error("toggle without irq");
  reset_quiet_a: assert property (disable iff (1'b0) i_reset |=> !irq && !o_timer_inout_pin_oe
    && !o_timer_output_pin_oe) else $error("outputs active at reset");
endmodule
bind mdt_timer mdt_timer_asserts u_chk (.i_mclk(i_mclk), .i_reset(i_reset), .i_address(i_address),
  .i_read(i_read), .i_write(i_write), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
  .i_port_direction_bit(i_port_direction_bit), .o_timer_inout_pin_oe(o_timer_inout_pin_oe),
  .o_timer_output_pin(o_timer_output_pin), .o_timer_output_pin_oe(o_timer_output_pin_oe),
  .o_timer_interrupt_request(o_timer_interrupt_request));

// ---- verif/testbench.sv ----
// Self-checking bench for the down-counter timer
`timescale 1ns/1ps
module testbench;
  logic        i_mclk, i_reset, i_read, i_write, i_dir;
  logic [4:0]  i_address;
  logic [31:0] i_writedata, o_readdata, q;
  logic [3:0]  i_byteenable;
  logic [7:0]  half;
  logic        o_waitrequest, o_pin, o_pin_oe, o_out, o_out_oe, o_irq, pulse, slow, lv, gate;
  wire logic   pin_wire;
  int          error_cnt, checks_done, n;
  assign pin_wire = o_pin_oe ? o_pin : pulse;
  mdt_timer dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_timer_inout_pin(pin_wire),
    .i_port_direction_bit(i_dir), .i_external_interrupt_gate_source(gate),
    .i_gate_timer_outputs(4'h0), .i_low_speed_clock(slow), .i_event_link_input(pulse),
    .o_timer_inout_pin(o_pin), .o_timer_inout_pin_oe(o_pin_oe), .o_timer_output_pin(o_out),
    .o_timer_output_pin_oe(o_out_oe), .o_timer_interrupt_request(o_irq));
  mdt_partner u_far (.i_mclk(i_mclk), .i_reset(i_reset), .i_half(half), .o_pulse(pulse),
    .o_slow_clk(slow));
  always #5 i_mclk = ~i_mclk;
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic hang();
    error_cnt++;
    $display("ERROR %0t wait ran out", $time);
    final_report();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input int tol, input string m);
    checks_done++;
    if ((^got) === 1'bx || got > exp + tol || got + tol < exp) begin
      error_cnt++;
      $display("ERROR %0t %s: got %h exp %h", $time, m, got, exp);
    end
  endtask
  // Request held until waitrequest is sampled low, then released
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    int k;
    k = 0;
    @(posedge i_mclk);
    i_address <= a;
    i_write <= w;
    i_read <= !w;
    i_writedata <= d;
    i_byteenable <= be;
    do begin
      @(posedge i_mclk);
      k++;
    end while (o_waitrequest !== 1'b0 && k < 20);
    if (k >= 20) hang();
    q = o_readdata;
    i_read <= 1'b0;
    i_write <= 1'b0;
  endtask
  task automatic irq_wait();
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_irq !== 1'b1 && n < 3000);
    if (n >= 3000) hang();
  endtask
  task automatic cfg(input logic [31:0] md, input logic [31:0] io, input logic [31:0] cnt);
    bus(1'b1, 5'h08, md, 4'hf);
    bus(1'b1, 5'h04, io, 4'hf);
    bus(1'b1, 5'h10, cnt, 4'hf);
    bus(1'b1, 5'h00, 32'h1, 4'hf);
    repeat (8) @(posedge i_mclk);
  endtask
  task automatic stop();
    bus(1'b1, 5'h00, 32'h4, 4'hf);
    repeat (4) @(posedge i_mclk);
  endtask
  task automatic t_regs();
    logic [4:0]  a [6] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h10, 5'h14};
    logic [31:0] e [6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'hffff, 32'h0};
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, a[i], 32'h0, 4'hf);
      chk(q, e[i], 0, "reset value");
    end
    bus(1'b1, 5'h10, 32'h1234, 4'hf);
    bus(1'b0, 5'h10, 32'h0, 4'hf);
    chk(q, 32'h1234, 0, "stopped write");
    bus(1'b1, 5'h10, 32'h5678, 4'h1);
    bus(1'b0, 5'h10, 32'h0, 4'hf);
    chk(q, 32'h1234, 0, "narrow write");
    $display("register test done");
  endtask
  task automatic t_timer();
    cfg(32'h0, 32'h0, 32'h3);
    irq_wait();
    irq_wait();
    chk(n, 4, 0, "underflow spacing");
    bus(1'b0, 5'h00, 32'h0, 4'hf);
    chk(q[1], 1, 0, "running status");
    bus(1'b1, 5'h10, 32'h7, 4'hf);
    repeat (3) irq_wait();
    chk(n, 8, 0, "running rewrite");
    bus(1'b1, 5'h00, 32'h0, 4'hf);
    repeat (6) @(posedge i_mclk);
    bus(1'b0, 5'h00, 32'h0, 4'hf);
    chk(q[1:0], 0, 0, "stop status");
    $display("timer test done");
  endtask
  task automatic t_pulse();
    i_dir <= 1'b0;
    cfg(32'h1, 32'h4, 32'h2);
    irq_wait();
    lv = o_out;
    irq_wait();
    chk(lv ^ o_out, 1, 0, "output toggle");
    chk(o_pin ^ o_out, 1, 0, "inout opposite level");
    chk(o_pin_oe, 1, 0, "inout driven");
    i_dir <= 1'b1;
    @(posedge i_mclk);
    chk(o_pin_oe, 0, 0, "inout released");
    stop();
    bus(1'b0, 5'h00, 32'h0, 4'hf);
    chk(q[2:0], 0, 0, "forced stop");
    chk(o_out, 0, 0, "level restored");
    bus(1'b1, 5'h04, 32'h1, 4'hf);
    @(posedge i_mclk);
    chk({o_out_oe, o_out}, 2'h1, 0, "enable and polarity");
    $display("pulse test done");
  endtask
  task automatic t_events();
    // Pulse mode on link source, then pin events, then pulse mode on low-speed source
    logic [31:0] md [3] = '{32'h51, 32'h02, 32'h41};
    int          sp [3] = '{40, 40, 32};
    for (int i = 0; i < 3; i++) begin
      cfg(md[i], 32'h4, 32'h1);
      half <= 8'h0a;
      irq_wait();
      irq_wait();
      lv = o_out;
      irq_wait();
      chk(n, sp[i], 0, "event spacing");
      chk(lv ^ o_out, 1, 0, "event toggle");
      half <= 8'h00;
      stop();
    end
    $display("event test done");
  endtask
  task automatic t_gate();
    stop();
    bus(1'b1, 5'h0c, 32'h4, 4'hf);
    gate <= 1'b0;
    cfg(32'h2, 32'h54, 32'h1);
    half <= 8'h0a;
    repeat (200) @(posedge i_mclk);
    bus(1'b0, 5'h10, 32'h0, 4'hf);
    chk(q, 1, 0, "closed gate");
    gate <= 1'b1;
    irq_wait();
    irq_wait();
    chk(n, 40, 0, "open gate spacing");
    half <= 8'h00;
    stop();
    $display("gate test done");
  endtask
  task automatic t_width();
    cfg(32'h3, 32'h1, 32'h100);
    half <= 8'd25;
    irq_wait();
    half <= 8'h00;
    bus(1'b0, 5'h10, 32'h0, 4'hf);
    chk(32'h100 - q[15:0], 25, 2, "high width");
    bus(1'b0, 5'h00, 32'h0, 4'hf);
    chk(q[4], 1, 0, "width edge flag");
    stop();
    // Short reload runs out inside a long high phase
    cfg(32'h3, 32'h1, 32'h10);
    half <= 8'd25;
    irq_wait();
    half <= 8'h00;
    bus(1'b0, 5'h00, 32'h0, 4'hf);
    chk(q[5], 1, 0, "width underflow flag");
    stop();
    $display("width test done");
  endtask
  task automatic t_period();
    cfg(32'h4, 32'h0, 32'h100);
    half <= 8'd20;
    irq_wait();
    irq_wait();
    bus(1'b0, 5'h10, 32'h0, 4'hf);
    irq_wait();
    // Unread buffer must keep the 40-cycle result over longer periods
    half <= 8'd30;
    repeat (3) irq_wait();
    bus(1'b0, 5'h10, 32'h0, 4'hf);
    chk(32'h100 - q[15:0], 40, 2, "held period");
    bus(1'b0, 5'h00, 32'h0, 4'hf);
    chk(q[4], 1, 0, "period edge flag");
    bus(1'b1, 5'h00, 32'h1, 4'h1);
    bus(1'b0, 5'h00, 32'h0, 4'hf);
    chk(q[5:4], 0, 0, "flags cleared");
    half <= 8'h00;
    stop();
    $display("period test done");
  endtask
  initial begin
    i_mclk = 1'b0;
    i_reset = 1'b1;
    i_read = 1'b0;
    i_write = 1'b0;
    i_dir = 1'b1;
    i_address = 5'h00;
    i_writedata = 32'h0;
    i_byteenable = 4'h0;
    half = 8'h00;
    gate = 1'b0;
    error_cnt = 0;
    checks_done = 0;
    repeat (6) @(posedge i_mclk);
    i_reset <= 1'b0;
    t_regs();
    t_timer();
    t_pulse();
    t_events();
    t_gate();
    t_width();
    t_period();
    final_report();
  end
endmodule
